/* src/eeprom_access_control.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Reserved address and control bits read zero
// - Nine-bit linear byte address, up to 511
// - Address register has no reset value
// - Data register feeds writes, receives read bytes
// - Mode bits pick atomic, erase or program
// - Mode writes ignored while write strobe set
// - Reset clears mode unless programming runs
// - Ready interrupt level while strobe clear, enabled
// - No ready interrupt during write or flash
// - Master enable self-clears four cycles later
// - Strobe starts programming only under master enable
// - No write start while flash self-programs
// - Hardware clears strobe when time elapsed
// - Write start stalls CPU two cycles
// - Read fetches byte, stalls CPU four cycles
// - Busy blocks reads and address changes
// - Write timed by counting RC oscillator cycles
// - Write in progress completes through reset
module eeprom_access_control
  import nv_access_pkg::*;
#(
  parameter int FULL_OSC_CYCLES  = PROG_FULL_OSC_CYCLES,
  parameter int SPLIT_OSC_CYCLES = PROG_SPLIT_OSC_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  // CPU I/O register access
  input  wire logic [IO_ADDR_W-1:0] io_addr_i,
  input  wire logic                 io_wr_i,
  input  wire logic                 io_rd_i,
  input  wire logic [DATA_W-1:0]    io_wdata_i,
  output var  logic [DATA_W-1:0]    io_rdata_o,
  // CPU status and control
  input  wire logic                 gie_i,
  input  wire logic                 flash_selfprog_active_i,
  output var  logic                 cpu_stall_o,
  output var  logic                 irq_o,
  // Calibrated RC oscillator
  input  wire logic                 rc_osc_i,
  // EEPROM array
  input  wire logic [DATA_W-1:0]    arr_rdata_i,
  output var  logic [ADDR_W-1:0]    arr_addr_o,
  output var  logic [DATA_W-1:0]    arr_wdata_o,
  output var  logic                 arr_erase_o,
  output var  logic                 arr_program_o
);

  generate
    if (FULL_OSC_CYCLES < 1 || FULL_OSC_CYCLES >= (1 << TIMER_W)) begin : g_bad_full
      $error("full programming count out of range");
    end
    if (SPLIT_OSC_CYCLES < 1 || SPLIT_OSC_CYCLES >= (1 << TIMER_W)) begin : g_bad_split
      $error("split programming count out of range");
    end
  endgenerate

  localparam logic [TIMER_W-1:0] FULL_LOAD  = TIMER_W'(FULL_OSC_CYCLES);
  localparam logic [TIMER_W-1:0] SPLIT_LOAD = TIMER_W'(SPLIT_OSC_CYCLES);

  // Register state
  logic [ADDR_W-1:0]  nv_byte_address;
  logic [DATA_W-1:0]  nv_byte_data;
  prog_mode_t         program_mode_bits;
  logic               ready_irq_enable;
  logic               master_write_enable;
  logic [STALL_W-1:0] mwe_cnt;
  logic [STALL_W-1:0] stall_cnt;
  prog_state_t        state;

  // Decoded accesses
  logic               ctrl_wr;
  logic               data_wr;
  logic               alow_wr;
  logic               ahigh_wr;
  logic               idle;
  logic               write_strobe;
  logic               start_write;
  logic               start_read;
  logic               mwe_set;
  prog_mode_t         next_mode;

  // Timer links
  logic               rc_tick;
  logic               timer_running;
  logic               timer_done;
  logic [TIMER_W-1:0] timer_load;

  assign ctrl_wr      = io_wr_i && (io_addr_i == OFS_CONTROL);
  assign data_wr      = io_wr_i && (io_addr_i == OFS_DATA);
  assign alow_wr      = io_wr_i && (io_addr_i == OFS_ADDR_LOW);
  assign ahigh_wr     = io_wr_i && (io_addr_i == OFS_ADDR_HIGH);
  assign idle         = (state == ST_IDLE);
  assign write_strobe = !idle;
  assign next_mode    = prog_mode_t'(io_wdata_i[BIT_MODE_HI:BIT_MODE_LO]);
  assign mwe_set      = ctrl_wr && io_wdata_i[BIT_MWE];

  // Enable must already stand before this write; reserved mode never starts
  assign start_write = ctrl_wr && io_wdata_i[BIT_WRITE]
                    && master_write_enable
                    && idle && !srst_i
                    && !flash_selfprog_active_i
                    && (next_mode != MODE_RSVD);

  assign start_read = ctrl_wr && io_wdata_i[BIT_READ]
                   && idle && !srst_i;

  assign timer_load = (next_mode == MODE_ATOMIC) ? FULL_LOAD : SPLIT_LOAD;

  nv_sync_rise u_rc_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .async_i (rc_osc_i),
    .rise_o  (rc_tick)
  );

  // Programming time counted in oscillator periods
  nv_prog_timer #(
    .CNT_W (TIMER_W)
  ) u_timer (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .load_i     (start_write),
    .load_val_i (timer_load),
    .tick_i     (rc_tick),
    .running_o  (timer_running),
    .done_o     (timer_done)
  );

  // Programming sequence; a running write is not cut by reset
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      case (state)
        ST_IDLE: begin
          if (start_write) begin
            state <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (timer_done) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Mode bits
  always_ff @(posedge clock_i) begin
    if (srst_i && idle) begin
      program_mode_bits <= MODE_ATOMIC;
    end else if (ce_i && ctrl_wr && idle && !srst_i) begin
      program_mode_bits <= next_mode;
    end
  end

  // Interrupt enable
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ready_irq_enable <= 1'b0;
    end else if (ce_i && ctrl_wr) begin
      ready_irq_enable <= io_wdata_i[BIT_IRQ_EN];
    end
  end

  // Master write enable, held for a fixed window
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      master_write_enable <= 1'b0;
      mwe_cnt             <= '0;
    end else if (ce_i) begin
      if (mwe_set) begin
        master_write_enable <= 1'b1;
        mwe_cnt             <= MWE_CYCLES;
      end else if (mwe_cnt != '0) begin
        mwe_cnt             <= mwe_cnt - 1'b1;
        master_write_enable <= (mwe_cnt != 3'h1);
      end
    end
  end

  // Address: no reset value, frozen while busy
  always_ff @(posedge clock_i) begin
    if (ce_i && idle) begin
      if (alow_wr) begin
        nv_byte_address[7:0] <= io_wdata_i;
      end
      if (ahigh_wr) begin
        nv_byte_address[8] <= io_wdata_i[0];
      end
    end
  end

  // Data: software load, or byte fetched by a read; kept while a write runs
  always_ff @(posedge clock_i) begin
    if (srst_i && idle) begin
      nv_byte_data <= DATA_RESET;
    end else if (ce_i) begin
      if (start_read) begin
        nv_byte_data <= arr_rdata_i;
      end else if (data_wr && idle) begin
        nv_byte_data <= io_wdata_i;
      end
    end
  end

  // CPU stall after a strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stall_cnt   <= '0;
      cpu_stall_o <= 1'b0;
    end else if (ce_i) begin
      if (start_write) begin
        stall_cnt   <= WRITE_STALL;
        cpu_stall_o <= 1'b1;
      end else if (start_read) begin
        stall_cnt   <= READ_STALL;
        cpu_stall_o <= 1'b1;
      end else if (stall_cnt != '0) begin
        stall_cnt   <= stall_cnt - 1'b1;
        cpu_stall_o <= (stall_cnt != 3'h1);
      end
    end
  end

  // Register read-back
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      io_rdata_o <= RDATA_RESET;
    end else if (ce_i && io_rd_i) begin
      case (io_addr_i)
        OFS_ADDR_LOW: begin
          io_rdata_o <= nv_byte_address[7:0];
        end
        OFS_ADDR_HIGH: begin
          io_rdata_o <= {7'h00, nv_byte_address[8]};
        end
        OFS_DATA: begin
          io_rdata_o <= nv_byte_data;
        end
        OFS_CONTROL: begin
          io_rdata_o <= {2'h0, program_mode_bits,
                         ready_irq_enable, master_write_enable,
                         write_strobe, 1'b0};
        end
        default: begin
          io_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // Ready interrupt, a level
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= ready_irq_enable && gie_i && idle
            && !flash_selfprog_active_i;
    end
  end

  // Array drive
  always_ff @(posedge clock_i) begin
    if (srst_i && idle) begin
      arr_erase_o   <= 1'b0;
      arr_program_o <= 1'b0;
    end else if (ce_i) begin
      arr_erase_o   <= (state == ST_PROG) && (program_mode_bits != MODE_WRITE);
      arr_program_o <= (state == ST_PROG) && (program_mode_bits != MODE_ERASE);
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      arr_addr_o  <= nv_byte_address;
      arr_wdata_o <= nv_byte_data;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i || !ce_i);

  sequence s_stall_two;
    cpu_stall_o [*2] ##1 !cpu_stall_o;
  endsequence

  sequence s_stall_four;
    cpu_stall_o [*4] ##1 !cpu_stall_o;
  endsequence

  a_resv_high_zero: assert property (
    io_rd_i && io_addr_i == OFS_ADDR_HIGH |=> io_rdata_o[7:1] == 7'h00)
    else $error("reserved address bits read nonzero");

  a_resv_ctrl_zero: assert property (
    io_rd_i && io_addr_i == OFS_CONTROL |=> io_rdata_o[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");

  a_mwe_window: assert property (
    mwe_set ##1 !mwe_set [*4] |=> !master_write_enable)
    else $error("master enable did not expire");

  a_mwe_holds: assert property (
    mwe_set |=> master_write_enable [*4])
    else $error("master enable dropped early");

  a_no_bare_strobe: assert property (
    ctrl_wr && io_wdata_i[BIT_WRITE] && !master_write_enable && idle
    |=> !write_strobe)
    else $error("write started without master enable");

  a_mode_frozen: assert property (
    write_strobe |=> $stable(program_mode_bits))
    else $error("mode changed while busy");

  a_write_stall: assert property (
    start_write |=> s_stall_two)
    else $error("write stall not two cycles");

  a_read_stall: assert property (
    start_read |=> s_stall_four)
    else $error("read stall not four cycles");

  a_read_fetch: assert property (
    start_read |=> nv_byte_data == $past(arr_rdata_i))
    else $error("read byte not captured");

  a_addr_frozen: assert property (
    write_strobe && $past(write_strobe) |-> $stable(nv_byte_address))
    else $error("address changed while busy");

  a_irq_level: assert property (
    ##1 irq_o == $past(ready_irq_enable && gie_i && idle && !flash_selfprog_active_i))
    else $error("ready interrupt level wrong");

  a_strobe_clear: assert property (
    $fell(write_strobe) |-> $past(state, 1) == ST_FINISH && $past(timer_done, 2))
    else $error("strobe cleared without elapsed time");

  a_no_flash_start: assert property (
    flash_selfprog_active_i && idle |=> !write_strobe)
    else $error("write started during flash programming");

  a_timer_busy: assert property (
    timer_running |-> write_strobe)
    else $error("programming timer ran while idle");

endmodule
`default_nettype wire

/* src/nv_access_pkg.sv */
package nv_access_pkg;

  // Widths
  localparam int ADDR_W    = 9;
  localparam int DATA_W    = 8;
  localparam int IO_ADDR_W = 6;
  localparam int STALL_W   = 3;
  localparam int TIMER_W   = 15;

  // I/O register offsets
  localparam logic [IO_ADDR_W-1:0] OFS_CONTROL   = 6'h1F;
  localparam logic [IO_ADDR_W-1:0] OFS_DATA      = 6'h20;
  localparam logic [IO_ADDR_W-1:0] OFS_ADDR_LOW  = 6'h21;
  localparam logic [IO_ADDR_W-1:0] OFS_ADDR_HIGH = 6'h22;

  // Control field positions
  localparam int BIT_READ    = 0;
  localparam int BIT_WRITE   = 1;
  localparam int BIT_MWE     = 2;
  localparam int BIT_IRQ_EN  = 3;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;

  // Values after reset
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;

  // Cycle counts on the CPU clock
  localparam logic [STALL_W-1:0] MWE_CYCLES   = 3'h4;
  localparam logic [STALL_W-1:0] WRITE_STALL  = 3'h2;
  localparam logic [STALL_W-1:0] READ_STALL   = 3'h4;

  // Programming times in microseconds, and oscillator cycles
  localparam int PROG_FULL_TIME_US    = 32'h0000_0D48;
  localparam int PROG_SPLIT_TIME_US   = 32'h0000_0708;
  localparam int PROG_FULL_OSC_CYCLES = 32'h0000_6700;
  localparam int PROG_SPLIT_OSC_CYCLES =
    PROG_FULL_OSC_CYCLES * PROG_SPLIT_TIME_US / PROG_FULL_TIME_US;

  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE  = 2'h1,
    MODE_WRITE  = 2'h2,
    MODE_RSVD   = 2'h3
  } prog_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_PROG   = 2'h1,
    ST_FINISH = 2'h3
  } prog_state_t;

endpackage

/* src/nv_prog_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module nv_prog_timer #(
  parameter int CNT_W = 15
) (
  // Clock and control
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Start and time base
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  input  wire logic             tick_i,
  // Status
  output var  logic             running_o,
  output var  logic             done_o
);

  logic [CNT_W-1:0] remain;

  // A running count survives reset so that programming completes;
  // an unknown power-up state falls through to the reset branch
  always_ff @(posedge clock_i) begin
    if (running_o) begin
      if (ce_i) begin
        done_o <= 1'b0;
        if (tick_i) begin
          remain <= remain - 1'b1;
          if (remain == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            running_o <= 1'b0;
            done_o    <= 1'b1;
          end
        end
      end
    end else if (srst_i) begin
      remain    <= '0;
      running_o <= 1'b0;
      done_o    <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (load_i) begin
        remain    <= load_val_i;
        running_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* src/nv_sync_rise.sv */
`timescale 1ns/10ps
`default_nettype none
module nv_sync_rise (
  // Clock and control
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // Asynchronous level in, rising-edge pulse out
  input  wire logic async_i,
  output var  logic rise_o
);

  logic meta;
  logic stable;
  logic last;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
      rise_o <= 1'b0;
    end else if (ce_i) begin
      meta   <= async_i;
      stable <= meta;
      last   <= stable;
      rise_o <= stable & ~last;
    end
  end

endmodule
`default_nettype wire

/* verif/eeprom_access_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module eeprom_access_control_tb;
  import nv_access_pkg::*;
  localparam int FULL  = 16;
  localparam int SPLIT = 8;
  localparam int RCC   = 7;
  logic                 clock_i   = 1'b0;
  logic                 srst_i    = 1'b1;
  logic                 ce_i      = 1'b1;
  logic                 rc_osc_i  = 1'b0;
  logic [IO_ADDR_W-1:0] io_addr_i = '0;
  logic                 io_wr_i   = 1'b0;
  logic                 io_rd_i   = 1'b0;
  logic [DATA_W-1:0]    io_wdata_i = '0;
  logic                 gie_i     = 1'b0;
  logic                 flash_i   = 1'b0;
  logic [DATA_W-1:0]    io_rdata_o;
  logic                 cpu_stall_o;
  logic                 irq_o;
  logic [DATA_W-1:0]    arr_rdata;
  logic [ADDR_W-1:0]    arr_addr;
  logic [DATA_W-1:0]    arr_wdata;
  logic                 arr_erase_o;
  logic                 arr_program_o;
  int                   fails     = 0;
  int                   cmp_count = 0;
  int                   cyc       = 0;

  always #10 clock_i = ~clock_i;
  always #70 rc_osc_i = ~rc_osc_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  eeprom_access_control #(.FULL_OSC_CYCLES(FULL), .SPLIT_OSC_CYCLES(SPLIT)) i_eeprom_access_control (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .gie_i(gie_i), .flash_selfprog_active_i(flash_i),
    .cpu_stall_o(cpu_stall_o), .irq_o(irq_o), .rc_osc_i(rc_osc_i), .arr_rdata_i(arr_rdata),
    .arr_addr_o(arr_addr), .arr_wdata_o(arr_wdata), .arr_erase_o(arr_erase_o), .arr_program_o(arr_program_o)
  );

  nv_array_model i_nv_array_model (
    .clock_i(clock_i), .arr_addr_i(arr_addr), .arr_wdata_i(arr_wdata),
    .arr_erase_i(arr_erase_o), .arr_program_i(arr_program_o), .arr_rdata_o(arr_rdata)
  );

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic io_write(input logic [IO_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock_i);
    io_addr_i  = a;
    io_wdata_i = d;
    io_wr_i    = 1'b1;
    @(negedge clock_i);
    io_wr_i = 1'b0;
  endtask

  task automatic io_read(input logic [IO_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clock_i);
    io_addr_i = a;
    io_rd_i   = 1'b1;
    @(negedge clock_i);
    io_rd_i = 1'b0;
    d = io_rdata_o;
  endtask

  task automatic chk_reg(input logic [IO_ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] v;
    io_read(a, v);
    `CHK(v, e)
  endtask

  // Counts stall cycles seen over the next eight cycles
  task automatic check_stall(input int n);
    int cnt;
    cnt = 0;
    repeat (8) begin
      // An unknown stall counts heavily so that it never passes
      cnt += (cpu_stall_o === 1'b1) ? 1 : ((cpu_stall_o === 1'b0) ? 0 : 100);
      @(negedge clock_i);
    end
    `CHK(cnt, n)
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (arr_erase_o !== 1'b0 || arr_program_o !== 1'b0) begin
      @(negedge clock_i);
      n++;
      if (n > 600) begin
        fails++;
        stop_test();
      end
    end
  endtask

  task automatic start_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
    gie_i = 1'b0;
    io_write(OFS_ADDR_HIGH, {7'h00, a[8]});
    io_write(OFS_ADDR_LOW, a[7:0]);
    io_write(OFS_DATA, d);
    io_write(OFS_CONTROL, 8'h0C);
    io_write(OFS_CONTROL, {2'b00, m, 4'b1010});
    gie_i = 1'b1;
  endtask

  task automatic t_read();
    i_nv_array_model.mem[9'h1FF] = 8'hA7;
    io_write(OFS_ADDR_HIGH, 8'hFF);
    chk_reg(OFS_ADDR_HIGH, 8'h01);
    io_write(OFS_ADDR_LOW, 8'hFF);
    io_write(OFS_CONTROL, 8'h01);
    check_stall(4);
    chk_reg(OFS_DATA, 8'hA7);
    chk_reg(OFS_CONTROL, 8'h00);
  endtask

  task automatic t_mwe();
    ce_i = 1'b0;
    io_write(OFS_CONTROL, 8'h0C);
    ce_i = 1'b1;
    chk_reg(OFS_CONTROL, 8'h00);
    io_write(OFS_CONTROL, 8'h04);
    chk_reg(OFS_CONTROL, 8'h04);
    repeat (3) @(negedge clock_i);
    chk_reg(OFS_CONTROL, 8'h00);
    io_write(OFS_CONTROL, 8'h04);
    repeat (5) @(negedge clock_i);
    io_write(OFS_CONTROL, 8'h02);
    check_stall(0);
    io_write(OFS_CONTROL, 8'h02);
    check_stall(0);
    io_write(OFS_CONTROL, 8'h06);
    check_stall(0);
    chk_reg(OFS_CONTROL, 8'h00);
    io_write(OFS_CONTROL, 8'h04);
    io_write(OFS_CONTROL, 8'h32);
    check_stall(0);
    `CHK({arr_erase_o, arr_program_o}, 2'b00)
  endtask

  task automatic t_flash();
    flash_i = 1'b1;
    gie_i   = 1'b1;
    io_write(OFS_CONTROL, 8'h0C);
    io_write(OFS_CONTROL, 8'h0A);
    check_stall(0);
    `CHK(irq_o, 1'b0)
    flash_i = 1'b0;
    repeat (3) @(negedge clock_i);
    `CHK(irq_o, 1'b1)
    gie_i = 1'b0;
    repeat (3) @(negedge clock_i);
    `CHK(irq_o, 1'b0)
  endtask

  task automatic t_write(input logic [1:0] m);
    logic [8:0] a;
    logic [7:0] e;
    int         t0;
    int         n;
    a = {1'b1, 6'h15, m};
    n = (m == 2'h0) ? FULL : SPLIT;
    e = (m == 2'h1) ? 8'hFF : ((m == 2'h2) ? 8'h82 : 8'h96);
    i_nv_array_model.mem[a] = 8'hC3;
    start_write(a, 8'h96, m);
    t0 = cyc;
    check_stall(2);
    `CHK({arr_erase_o, arr_program_o}, {m != 2'h2, m != 2'h1})
    `CHK(irq_o, 1'b0)
    chk_reg(OFS_CONTROL, {2'b00, m, 4'b1010});
    io_write(OFS_CONTROL, 8'h38);
    io_write(OFS_ADDR_LOW, ~a[7:0]);
    io_write(OFS_CONTROL, 8'h09);
    check_stall(0);
    chk_reg(OFS_CONTROL, {2'b00, m, 4'b1010});
    chk_reg(OFS_ADDR_LOW, a[7:0]);
    wait_done();
    `CHK((cyc - t0 >= (n - 1) * RCC) && (cyc - t0 <= (n + 1) * RCC + 8), 1'b1)
    repeat (4) @(negedge clock_i);
    chk_reg(OFS_CONTROL, {2'b00, m, 4'b1000});
    `CHK(irq_o, 1'b1)
    `CHK(i_nv_array_model.mem[a], e)
  endtask

  task automatic t_reset_mid();
    logic [7:0] v;
    i_nv_array_model.mem[9'h0AA] = 8'h5C;
    start_write(9'h0AA, 8'h0F, 2'h2);
    repeat (6) @(negedge clock_i);
    srst_i = 1'b1;
    @(negedge clock_i);
    srst_i = 1'b0;
    `CHK(arr_program_o, 1'b1)
    io_read(OFS_CONTROL, v);
    `CHK(v & 8'h32, 8'h22)
    wait_done();
    repeat (4) @(negedge clock_i);
    `CHK(i_nv_array_model.mem[9'h0AA], 8'h0C)
    io_write(OFS_CONTROL, 8'h10);
    srst_i = 1'b1;
    @(negedge clock_i);
    srst_i = 1'b0;
    chk_reg(OFS_CONTROL, 8'h00);
  endtask

  initial begin
    repeat (3) @(negedge clock_i);
    srst_i = 1'b0;
    chk_reg(OFS_CONTROL, 8'h00);
    chk_reg(6'h10, 8'h00);
    t_read();
    t_mwe();
    t_flash();
    for (int m = 0; m < 3; m++) begin
      t_write(2'(m));
    end
    t_reset_mid();
    stop_test();
  end
endmodule
`default_nettype wire

/* verif/nv_array_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nv_array_model (
  // Clock
  input  wire logic       clock_i,
  // Array side of the block
  input  wire logic [8:0] arr_addr_i,
  input  wire logic [7:0] arr_wdata_i,
  input  wire logic       arr_erase_i,
  input  wire logic       arr_program_i,
  output var  logic [7:0] arr_rdata_o
);
  logic [7:0] mem [0:511];
  logic       was_erase;
  logic       was_program;

  assign arr_rdata_o = mem[arr_addr_i];

  // Cell contents change only once an operation ends
  always @(posedge clock_i) begin
    if ((was_erase && !arr_erase_i) || (was_program && !arr_program_i)) begin
      mem[arr_addr_i] <= (was_erase ? 8'hFF : mem[arr_addr_i]) & (was_program ? arr_wdata_i : 8'hFF);
    end
    was_erase   <= arr_erase_i;
    was_program <= arr_program_i;
  end
endmodule
`default_nettype wire
